// ===== ssr_pkg.sv
// shared types and constants for the status, service request and trigger block
package ssr_pkg;

  // status byte bit positions
  localparam int unsigned SBIT_BUSY = 0;
  localparam int unsigned SBIT_SEQ_RUN = 1;
  localparam int unsigned SBIT_ERR_QUEUE = 2;
  localparam int unsigned SBIT_QSUM = 3;
  localparam int unsigned SBIT_MAV = 4;
  localparam int unsigned SBIT_ESB = 5;
  localparam int unsigned SBIT_MSS = 6;
  localparam int unsigned SBIT_OSUM = 7;

  // mask bits software may program; the summary position is never writable
  localparam logic [7:0] MASK_WRITABLE = 8'hbf;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // self-test error bits reported by each query
  localparam logic [7:0] TST_BASIC_BITS = 8'h17;
  localparam logic [7:0] TST_DIAG_BITS = 8'hf7;
  localparam logic [7:0] TST_PASS = 8'h00;

  // trigger levels and setpoints
  localparam int unsigned LEVEL_W = 16;
  localparam logic [15:0] LEVEL_RESET = 16'h0000;

  // command opcodes on the command port
  typedef enum logic [3:0] {
    SSR_OP_NOP = 4'h0,
    SSR_OP_SET_MASK = 4'h1,
    SSR_OP_QRY_MASK = 4'h2,
    SSR_OP_QRY_STATUS = 4'h3,
    SSR_OP_SERIAL_POLL = 4'h4,
    SSR_OP_BUS_TRIG = 4'h5,
    SSR_OP_GROUP_TRIG = 4'h6,
    SSR_OP_INITIATE = 4'h7,
    SSR_OP_CONT_ARM = 4'h8,
    SSR_OP_TRIG_SRC = 4'h9,
    SSR_OP_SET_TRIG_VOLT = 4'ha,
    SSR_OP_SET_TRIG_CURR = 4'hb,
    SSR_OP_SELF_TEST = 4'hc,
    SSR_OP_DIAG_TEST = 4'hd,
    SSR_OP_WAIT_CONT = 4'he
  } ssr_op_t;

  // one command as presented by the bus controller side
  typedef struct packed {
    logic valid;
    ssr_op_t op;
    logic [15:0] data;
  } ssr_cmd_t;

  // live summary sources feeding the status byte
  typedef struct packed {
    logic operation_summary;
    logic event_summary;
    logic message_available;
    logic questionable_summary;
    logic error_queue_pending;
    logic sequence_running;
    logic busy;
  } ssr_src_t;

  // complete state of the top module
  typedef struct packed {
    logic [7:0] service_request_mask;
    logic rqs;
    logic mss_d;
    logic armed;
    logic waiting_for_trigger;
    logic continuous_arming;
    logic src_bus;
    logic [15:0] trigger_voltage_level;
    logic [15:0] trigger_current_level;
    logic [15:0] setpoint_volt;
    logic [15:0] setpoint_curr;
    logic wai_hold;
    logic tst_busy;
    logic tst_diag;
    logic tst_start;
    logic rsp_valid;
    logic [7:0] rsp_data;
  } ssr_state_t;

endpackage

// ===== ssr_selftest.sv
// packs subtest failures into the self-test answer code
`timescale 1ns/10ps
module ssr_selftest (
  // inputs
  input wire logic [7:0] fail_i,
  input wire logic diag_i,
  // outputs
  output logic [7:0] code_o
);

  // keep only the bits the chosen query may report
  function automatic logic [7:0] pack_code(input logic [7:0] fails, input logic [7:0] allowed);
    pack_code = fails & allowed;
  endfunction

  assign code_o = diag_i ? pack_code(fail_i, ssr_pkg::TST_DIAG_BITS)
                         : pack_code(fail_i, ssr_pkg::TST_BASIC_BITS);

endmodule

// ===== ssr_summary.sv
// status byte assembly and master summary evaluation
`timescale 1ns/10ps
module ssr_summary (
  // inputs
  input wire ssr_pkg::ssr_src_t src_i,
  input wire logic [7:0] mask_i,
  input wire logic rqs_i,
  // outputs
  output logic mss_o,
  output logic [7:0] sbyte_query_o,
  output logic [7:0] sbyte_poll_o
);

  logic [7:0] raw;
  logic [7:0] hits;

  // summary position is left zero so it can never feed itself
  assign raw = {src_i.operation_summary, 1'b0, src_i.event_summary, src_i.message_available,
                src_i.questionable_summary, src_i.error_queue_pending,
                src_i.sequence_running, src_i.busy};

  // per-bit enable gating
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_and
      assign hits[g] = raw[g] & mask_i[g];
    end
  endgenerate

  // or of all enabled bits, live every cycle
  assign mss_o = |(hits & ssr_pkg::MASK_WRITABLE);
  assign sbyte_query_o = raw | ({7'h00, mss_o} << ssr_pkg::SBIT_MSS);
  assign sbyte_poll_o = raw | ({7'h00, rqs_i} << ssr_pkg::SBIT_MSS);

endmodule

// ===== ssr_trigger.sv
// status byte, service request mask, bus trigger, self-test and wait-to-continue
`timescale 1ns/10ps

// What this block does
// - mask is 0..255, bit 6 never programmable
// - enabled status bits ORed set bit 6
// - request flag clears on poll, summary does not
// - status byte layout from operation to busy
// - mask query returns present mask
// - status query shows summary, clears nothing
// - serial poll shows request flag, then clears
// - status bits clear only via their sources
// - bus trigger needs bus source, armed, waiting
// - without continuous arming, initiate arms once
// - unarmed trigger does nothing, no error
// - firing loads levels, clears waiting flag
// - continuous arming rearms and sets waiting
// - triggers act only when addressed listener
// - output off ignores bus triggers
// - self-test runs all, zero means pass
// - basic self-test reports bits 0,1,2,4
// - bits 5..7 only from extended diagnostic
// - wait holds commands until all complete
module ssr_trigger (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // command port from the bus controller side
  input wire ssr_pkg::ssr_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  // device context
  input wire ssr_pkg::ssr_src_t src_i,
  input wire logic listener_i,
  input wire logic output_on_i,
  input wire logic ops_busy_i,
  // self-test engine
  output logic tst_start_o,
  output logic tst_diag_o,
  input wire logic tst_done_i,
  input wire logic [7:0] tst_fail_i,
  // trigger and output levels, summary and request flag
  output logic waiting_for_trigger_o,
  output logic armed_o,
  output logic trig_fire_o,
  output logic [15:0] setpoint_volt_o,
  output logic [15:0] setpoint_curr_o,
  output logic mss_o,
  output logic rqs_o
);

  ssr_pkg::ssr_state_t st_r;
  ssr_pkg::ssr_state_t st_nxt;
  // strobes decoded from the command port and the live summary
  logic accept;
  logic mss;
  logic [7:0] sbyte_query;
  logic [7:0] sbyte_poll;
  logic [7:0] tst_code;
  logic is_trig;
  logic fire;
  logic rqs_set;
  logic poll_acc;

  // status byte and summary, combinational so they follow sources at once
  ssr_summary u_summary (
    .src_i(src_i),
    .mask_i(st_r.service_request_mask),
    .rqs_i(st_r.rqs),
    .mss_o(mss),
    .sbyte_query_o(sbyte_query),
    .sbyte_poll_o(sbyte_poll)
  );

  // self-test answer packing
  ssr_selftest u_selftest (
    .fail_i(tst_fail_i),
    .diag_i(st_r.tst_diag),
    .code_o(tst_code)
  );

  // commands stall while a wait or a self-test is outstanding
  assign cmd_ready_o = !st_r.wai_hold && !st_r.tst_busy;
  assign accept = cmd_i.valid && cmd_ready_o && ce_i;
  assign is_trig = accept && (cmd_i.op == ssr_pkg::SSR_OP_BUS_TRIG ||
                              cmd_i.op == ssr_pkg::SSR_OP_GROUP_TRIG);

  // all firing conditions in one term
  assign fire = is_trig && listener_i && output_on_i && st_r.src_bus
                && st_r.armed && st_r.waiting_for_trigger;

  // request flag rises with the summary; a new rise beats a poll clear
  assign rqs_set = mss && !st_r.mss_d;
  assign poll_acc = accept && cmd_i.op == ssr_pkg::SSR_OP_SERIAL_POLL;

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.tst_start = 1'b0;
    st_nxt.mss_d = mss;
    st_nxt.rqs = rqs_set || (st_r.rqs && !poll_acc);
    // wait ends once earlier work and level changes settle
    if (st_r.wai_hold && !ops_busy_i) begin
      st_nxt.wai_hold = 1'b0;
    end
    // all subtests report together, so no early exit on a failure
    if (st_r.tst_busy && tst_done_i) begin
      st_nxt.tst_busy = 1'b0;
      st_nxt.rsp_valid = 1'b1;
      st_nxt.rsp_data = tst_code;
    end
    if (accept) begin
      case (cmd_i.op)
        ssr_pkg::SSR_OP_SET_MASK: begin
          st_nxt.service_request_mask = cmd_i.data[7:0] & ssr_pkg::MASK_WRITABLE;
        end
        ssr_pkg::SSR_OP_QRY_MASK: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = st_r.service_request_mask;
        end
        ssr_pkg::SSR_OP_QRY_STATUS: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = sbyte_query;
        end
        ssr_pkg::SSR_OP_SERIAL_POLL: begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = sbyte_poll;
        end
        ssr_pkg::SSR_OP_INITIATE: begin
          st_nxt.armed = 1'b1;
          st_nxt.waiting_for_trigger = 1'b1;
        end
        ssr_pkg::SSR_OP_CONT_ARM: begin
          st_nxt.continuous_arming = cmd_i.data[0];
          if (cmd_i.data[0]) begin
            st_nxt.armed = 1'b1;
            st_nxt.waiting_for_trigger = 1'b1;
          end
        end
        ssr_pkg::SSR_OP_TRIG_SRC: begin
          st_nxt.src_bus = cmd_i.data[0];
        end
        ssr_pkg::SSR_OP_SET_TRIG_VOLT: begin
          st_nxt.trigger_voltage_level = cmd_i.data;
        end
        ssr_pkg::SSR_OP_SET_TRIG_CURR: begin
          st_nxt.trigger_current_level = cmd_i.data;
        end
        ssr_pkg::SSR_OP_SELF_TEST, ssr_pkg::SSR_OP_DIAG_TEST: begin
          st_nxt.tst_busy = 1'b1;
          st_nxt.tst_start = 1'b1;
          st_nxt.tst_diag = (cmd_i.op == ssr_pkg::SSR_OP_DIAG_TEST);
        end
        ssr_pkg::SSR_OP_WAIT_CONT: begin
          st_nxt.wai_hold = 1'b1;
        end
        default: begin
          // triggers are handled below; unknown opcodes are dropped
        end
      endcase
    end
    // a trigger that cannot fire leaves everything untouched
    if (fire) begin
      st_nxt.setpoint_volt = st_r.trigger_voltage_level;
      st_nxt.setpoint_curr = st_r.trigger_current_level;
      st_nxt.armed = st_r.continuous_arming;
      st_nxt.waiting_for_trigger = st_r.continuous_arming;
    end
  end

  // state register; enable low freezes everything
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.service_request_mask <= ssr_pkg::MASK_RESET;
      st_r.trigger_voltage_level <= ssr_pkg::LEVEL_RESET;
      st_r.trigger_current_level <= ssr_pkg::LEVEL_RESET;
      st_r.setpoint_volt <= ssr_pkg::LEVEL_RESET;
      st_r.setpoint_curr <= ssr_pkg::LEVEL_RESET;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign rsp_valid_o = st_r.rsp_valid;
  assign rsp_data_o = st_r.rsp_data;
  assign tst_start_o = st_r.tst_start;
  assign tst_diag_o = st_r.tst_diag;
  assign waiting_for_trigger_o = st_r.waiting_for_trigger;
  assign armed_o = st_r.armed;
  assign trig_fire_o = fire;
  assign setpoint_volt_o = st_r.setpoint_volt;
  assign setpoint_curr_o = st_r.setpoint_curr;
  assign mss_o = mss;
  assign rqs_o = st_r.rqs;

  // checks kept beside the logic they guard
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_mask_bit6;
    accept && cmd_i.op == ssr_pkg::SSR_OP_SET_MASK |=> !st_r.service_request_mask[6];
  endproperty
  a_mask_bit6: assert property (p_mask_bit6) else $error("mask bit 6 was programmed");

  property p_mss_live;
    (|({src_i.operation_summary, 1'b0, src_i.event_summary, src_i.message_available,
        src_i.questionable_summary, src_i.error_queue_pending, src_i.sequence_running,
        src_i.busy} & st_r.service_request_mask)) == mss_o;
  endproperty
  a_mss_live: assert property (p_mss_live) else $error("summary does not follow sources");

  property p_poll_clears;
    poll_acc && !rqs_set |=> !rqs_o ##0 rsp_valid_o && rsp_data_o[6] == $past(st_r.rqs);
  endproperty
  a_poll_clears: assert property (p_poll_clears) else $error("serial poll answer wrong");

  property p_query_keeps;
    accept && cmd_i.op == ssr_pkg::SSR_OP_QRY_STATUS && st_r.rqs |=> rqs_o;
  endproperty
  a_query_keeps: assert property (p_query_keeps) else $error("status query cleared a flag");

  property p_fire_loads;
    fire && ce_i |=> setpoint_volt_o == $past(st_r.trigger_voltage_level)
      && setpoint_curr_o == $past(st_r.trigger_current_level)
      && waiting_for_trigger_o == $past(st_r.continuous_arming);
  endproperty
  a_fire_loads: assert property (p_fire_loads) else $error("trigger did not load levels");

  property p_no_fire_blocked;
    is_trig && (!st_r.armed || !listener_i || !output_on_i || !st_r.src_bus) |=>
      $stable(setpoint_volt_o) && $stable(armed_o);
  endproperty
  a_no_fire_blocked: assert property (p_no_fire_blocked) else $error("blocked trigger fired");

  property p_rearm;
    fire && ce_i && st_r.continuous_arming |=> armed_o && waiting_for_trigger_o;
  endproperty
  a_rearm: assert property (p_rearm) else $error("continuous arming did not rearm");

  property p_wait_holds;
    st_r.wai_hold && ops_busy_i |-> !cmd_ready_o;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("command taken during wait");

  // a reply right after a busy cycle can only be a self-test code
  property p_basic_tst;
    $past(st_r.tst_busy) && rsp_valid_o && !st_r.tst_diag |->
      rsp_data_o[7:5] == 3'h0 && !rsp_data_o[3];
  endproperty
  a_basic_tst: assert property (p_basic_tst) else $error("basic test reported diag bits");

  property p_diag_code;
    $past(st_r.tst_busy) && rsp_valid_o && st_r.tst_diag |-> !rsp_data_o[3];
  endproperty
  a_diag_code: assert property (p_diag_code) else $error("diag code bit 3 set");

  property p_tst_start;
    accept && (cmd_i.op == ssr_pkg::SSR_OP_SELF_TEST ||
               cmd_i.op == ssr_pkg::SSR_OP_DIAG_TEST) |=> tst_start_o && !cmd_ready_o;
  endproperty
  a_tst_start: assert property (p_tst_start) else $error("self-test did not start");

  property p_tst_pulse;
    tst_start_o && ce_i |=> !tst_start_o;
  endproperty
  a_tst_pulse: assert property (p_tst_pulse) else $error("start pulse too long");

  // query answers come one cycle after the command is taken
  property p_mask_query;
    accept && cmd_i.op == ssr_pkg::SSR_OP_QRY_MASK |=>
      rsp_valid_o && rsp_data_o == $past(st_r.service_request_mask);
  endproperty
  a_mask_query: assert property (p_mask_query) else $error("mask query answer wrong");

  property p_query_summary;
    accept && cmd_i.op == ssr_pkg::SSR_OP_QRY_STATUS |=>
      rsp_valid_o && rsp_data_o[6] == $past(mss_o);
  endproperty
  a_query_summary: assert property (p_query_summary) else $error("query bit 6 wrong");

  // the top source bit skips the summary position, the rest map straight
  property p_layout;
    accept && cmd_i.op == ssr_pkg::SSR_OP_QRY_STATUS |=>
      rsp_data_o[7] == $past(src_i[6]) && rsp_data_o[5:0] == $past(src_i[5:0]);
  endproperty
  a_layout: assert property (p_layout) else $error("status layout wrong");

  // summary and request flag
  property p_rqs_rise;
    mss_o && !st_r.mss_d && ce_i |=> rqs_o;
  endproperty
  a_rqs_rise: assert property (p_rqs_rise) else $error("request flag missed a rise");

  property p_mask_zero;
    accept && cmd_i.op == ssr_pkg::SSR_OP_SET_MASK && cmd_i.data[7:0] == 8'h00 |=> !mss_o;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("summary kept without mask");

  // trigger gating; a blocked trigger must leave no trace
  property p_single_arm;
    fire && !st_r.continuous_arming |=> !armed_o && !waiting_for_trigger_o;
  endproperty
  a_single_arm: assert property (p_single_arm) else $error("single arm not spent");

  property p_unarmed_quiet;
    is_trig && !st_r.armed |=> !rsp_valid_o && $stable(waiting_for_trigger_o);
  endproperty
  a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("unarmed trigger acted");

  property p_not_listener;
    is_trig && !listener_i |=> $stable(setpoint_volt_o) && $stable(waiting_for_trigger_o);
  endproperty
  a_not_listener: assert property (p_not_listener) else $error("deaf trigger acted");

  property p_output_off;
    is_trig && !output_on_i |=> $stable(setpoint_curr_o) && $stable(waiting_for_trigger_o);
  endproperty
  a_output_off: assert property (p_output_off) else $error("trigger acted with output off");

  property p_src_not_bus;
    is_trig && !st_r.src_bus |=> $stable(setpoint_volt_o) && $stable(armed_o);
  endproperty
  a_src_not_bus: assert property (p_src_not_bus) else $error("trigger from wrong source");

  property p_not_waiting;
    is_trig && !st_r.waiting_for_trigger |=> $stable(setpoint_curr_o);
  endproperty
  a_not_waiting: assert property (p_not_waiting) else $error("trigger while not waiting");

  // wait hold persists while work is pending and lifts the cycle after
  property p_wait_stays;
    st_r.wai_hold && ops_busy_i |=> st_r.wai_hold;
  endproperty
  a_wait_stays: assert property (p_wait_stays) else $error("wait hold dropped early");

  property p_wait_release;
    st_r.wai_hold && !ops_busy_i && ce_i |=> cmd_ready_o;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait hold stuck");

endmodule

// ===== ssr_trigger_test.sv
// self-checking testbench for the status, service request and trigger block
`timescale 1ns/10ps
module ssr_trigger_test;
  logic core_clk_i, rst_n_i, cmd_ready_o, rsp_valid_o, tst_start_o, tst_diag_o, tst_done_i;
  logic listener, out_on, busy, waiting_o, armed_o, fire_o, mss_o, rqs_o, fire;
  logic [7:0] rsp_data_o, tst_fail_i, pat, rsp;
  logic [15:0] sp_volt, sp_curr;
  ssr_pkg::ssr_cmd_t cmd;
  ssr_pkg::ssr_src_t src;
  int n_mismatch = 0;
  int checks_done = 0;

  ssr_trigger i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .cmd_i(cmd),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .src_i(src), .listener_i(listener), .output_on_i(out_on), .ops_busy_i(busy),
    .tst_start_o(tst_start_o), .tst_diag_o(tst_diag_o), .tst_done_i(tst_done_i),
    .tst_fail_i(tst_fail_i), .waiting_for_trigger_o(waiting_o), .armed_o(armed_o),
    .trig_fire_o(fire_o), .setpoint_volt_o(sp_volt), .setpoint_curr_o(sp_curr),
    .mss_o(mss_o), .rqs_o(rqs_o)
  );

  ssr_tst_model i_tst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(tst_start_o),
    .fail_pattern_i(pat), .done_o(tst_done_i), .fail_o(tst_fail_i)
  );

  // clock
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // held until an edge sees ready; trigger fire noted before that edge
  task automatic send(input ssr_pkg::ssr_op_t op, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    #1 cmd = '{valid: 1'b1, op: op, data: d};
    #1;
    while (cmd_ready_o !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      #2 n++;
    end
    fire = fire_o;
    @(posedge core_clk_i);
    #1 cmd.valid = 1'b0;
    rsp = rsp_valid_o ? rsp_data_o : 8'hxx;
  endtask

  task automatic selftest(input logic diag, input logic [7:0] p, input logic [7:0] e);
    int n;
    n = 0;
    pat = p;
    send(diag ? ssr_pkg::SSR_OP_DIAG_TEST : ssr_pkg::SSR_OP_SELF_TEST, 16'h0000);
    while (rsp_valid_o !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk(rsp_valid_o ? rsp_data_o : 8'hxx, e);
    chk(tst_diag_o, diag);
  endtask

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    rst_n_i = 1'b0;
    cmd = '0;
    src = '0;
    listener = 1'b1;
    out_on = 1'b1;
    busy = 1'b0;
    pat = 8'h00;
    repeat (2) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    send(ssr_pkg::SSR_OP_QRY_MASK, 16'h0000);
    chk(rsp, 8'h00);
    // one source at a time lands on its own status bit
    for (int i = 0; i < 7; i++) begin
      src = 7'(1 << i);
      send(ssr_pkg::SSR_OP_QRY_STATUS, 16'h0000);
      chk(rsp, (i == 6) ? 8'h80 : 8'(1 << i));
    end
    // every source active, so the full byte shows once the mask opens
    src = '1;
    send(ssr_pkg::SSR_OP_SET_MASK, 16'h00ff);
    send(ssr_pkg::SSR_OP_QRY_MASK, 16'h0000);
    chk(rsp, 8'hbf);
    chk(mss_o, 1'b1);
    chk(rqs_o, 1'b1);
    send(ssr_pkg::SSR_OP_QRY_STATUS, 16'h0000);
    chk(rsp, 8'hff);
    send(ssr_pkg::SSR_OP_QRY_STATUS, 16'h0000);
    chk(rsp, 8'hff);
    send(ssr_pkg::SSR_OP_SERIAL_POLL, 16'h0000);
    chk(rsp, 8'hff);
    chk(rqs_o, 1'b0);
    send(ssr_pkg::SSR_OP_SERIAL_POLL, 16'h0000);
    chk(rsp, 8'hbf);
    send(ssr_pkg::SSR_OP_QRY_STATUS, 16'h0000);
    chk(rsp, 8'hff);
    send(ssr_pkg::SSR_OP_SET_MASK, 16'h0000);
    chk(mss_o, 1'b0);
    src = '0;
    send(ssr_pkg::SSR_OP_QRY_STATUS, 16'h0000);
    chk(rsp, 8'h00);
    // trigger gating and loading
    send(ssr_pkg::SSR_OP_SET_TRIG_VOLT, 16'h1234);
    send(ssr_pkg::SSR_OP_SET_TRIG_CURR, 16'h0abc);
    send(ssr_pkg::SSR_OP_TRIG_SRC, 16'h0001);
    send(ssr_pkg::SSR_OP_INITIATE, 16'h0000);
    chk(waiting_o, 1'b1);
    listener = 1'b0;
    send(ssr_pkg::SSR_OP_BUS_TRIG, 16'h0000);
    chk(fire, 1'b0);
    listener = 1'b1;
    out_on = 1'b0;
    send(ssr_pkg::SSR_OP_BUS_TRIG, 16'h0000);
    chk(fire, 1'b0);
    out_on = 1'b1;
    send(ssr_pkg::SSR_OP_BUS_TRIG, 16'h0000);
    chk(fire, 1'b1);
    chk(sp_volt, 16'h1234);
    chk(sp_curr, 16'h0abc);
    chk(waiting_o, 1'b0);
    send(ssr_pkg::SSR_OP_BUS_TRIG, 16'h0000);
    chk(fire, 1'b0);
    send(ssr_pkg::SSR_OP_CONT_ARM, 16'h0001);
    send(ssr_pkg::SSR_OP_INITIATE, 16'h0000);
    send(ssr_pkg::SSR_OP_GROUP_TRIG, 16'h0000);
    chk(fire, 1'b1);
    chk(waiting_o & armed_o, 1'b1);
    send(ssr_pkg::SSR_OP_TRIG_SRC, 16'h0000);
    send(ssr_pkg::SSR_OP_BUS_TRIG, 16'h0000);
    chk(fire, 1'b0);
    // self-test codes
    selftest(1'b0, 8'h00, 8'h00);
    selftest(1'b0, 8'hff, 8'h17);
    selftest(1'b1, 8'hff, 8'hf7);
    // wait-to-continue holds the port until pending work ends
    busy = 1'b1;
    send(ssr_pkg::SSR_OP_WAIT_CONT, 16'h0000);
    repeat (3) @(posedge core_clk_i);
    #1 chk(cmd_ready_o, 1'b0);
    busy = 1'b0;
    send(ssr_pkg::SSR_OP_QRY_MASK, 16'h0000);
    chk(rsp, 8'h00);
    wrap_up();
  end
endmodule

// ===== ssr_tst_model.sv
// self-test engine stand-in that answers each start pulse after a delay
`timescale 1ns/10ps
module ssr_tst_model #(
  parameter int DLY = 3
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // start request and failure pattern chosen by the bench
  input wire logic start_i,
  input wire logic [7:0] fail_pattern_i,
  // answer
  output logic done_o,
  output logic [7:0] fail_o
);
  int cnt;
  // every subtest runs, so the whole pattern comes back at once
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt == 1);
      if (start_i) cnt <= DLY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
  // lines flip outside done so stale bits never look valid
  assign fail_o = done_o ? fail_pattern_i : ~fail_pattern_i;
endmodule
